// ### rtl/sp_consts.svh
// register offsets, reset values and timing counts of the serial port
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH

// byte offsets on the register bus
`define SP_CTRL_OFS 8'h00
`define SP_BUF_OFS 8'h04

// reset values
`define SP_CTRL_RESET 9'h000
`define SP_BUF_RESET 8'h00

// mode select codes {mode_select_high, mode_select_low}
`define SP_MODE_SYNC 2'h0
`define SP_MODE_ASYNC 2'h1

// synchronous mode: period, data lead before the falling edge, rising phase
`define SP_M0_FAST_PER 4'h4
`define SP_M0_FAST_LEAD 4'h1
`define SP_M0_FAST_RISE 4'h3
`define SP_M0_SLOW_PER 4'hc
`define SP_M0_SLOW_LEAD 4'h3
`define SP_M0_SLOW_RISE 4'h9
`define SP_M0_LAST_BIT 3'h7

// asynchronous mode: slice counter and vote sample slices (8th, 9th, 10th)
`define SP_M1_LAST_SLICE 4'hf
`define SP_M1_VOTE_A 4'h7
`define SP_M1_VOTE_B 4'h8
`define SP_M1_VOTE_C 4'h9
`define SP_M1_RX_LAST 4'h9
`define SP_M1_TX_STOP 4'h9
`define SP_M1_TX_END 4'ha

`endif

// ### rtl/sp_pkg.sv
// types shared by the serial port design
package sp_pkg;

   // control register fields, bit 8 down to bit 0
   typedef struct packed {
      logic double_rate;
      logic mode_select_high;
      logic mode_select_low;
      logic multiproc_rate_bit;
      logic rx_enable;
      logic spare;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } sp_ctrl_t;

   // captured address phase of an AHB-Lite transfer
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } sp_ahb_req_t;

   typedef enum logic [2:0] {
      SP_M0_IDLE = 3'b001,
      SP_M0_TX = 3'b010,
      SP_M0_RX = 3'b100
   } sp_m0_state_t;

   typedef enum logic [1:0] {
      SP_RX1_HUNT = 2'b01,
      SP_RX1_RECV = 2'b10
   } sp_rx1_state_t;

endpackage : sp_pkg

// ### rtl/sp_serial_port.sv
// serial port with synchronous shifter and asynchronous framer on AHB-Lite
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "sp_consts.svh"

// What this block does
// - buffer writes go to transmit register, reads come from receive buffer
// - sync mode: data both ways on receive pin, shift clock on transmit pin
// - sync mode: eight bits per frame, least significant bit first
// - sync mode: shift rate clock/12 when rate bit low, clock/4 when high
// - sync mode: buffer write starts clocking out all eight bits
// - fast rate: data one clock before fall, clock low two clocks
// - slow rate: data three clocks before fall, clock low six clocks
// - sync mode: transmit-done set in the state after the last bit
// - sync receive only while enabled and receive-done clear, rising edge
// - sync receive-done set after last rising edge; stalls until cleared
// - async frame: low start, eight data bits LSB first, high stop
// - async bit rate is timer overflow rate divided by 16 or 32
// - async transmit aligns to the divide-by-16 rollovers, not the write
// - async transmit-done set at the tenth rollover after the write
// - receiver hunts falling edge at 16x rate, then resets slice counter
// - each bit is majority of samples in slices 8, 9 and 10
// - start bit sampled high aborts the frame and resumes hunting
// - frame accepted only if receive-done clear and stop or rate bit allow
// - receiver resumes hunting in the middle of the stop bit
module sp_serial_port (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // baud source, one-cycle pulse on this clock
   input wire logic timer_overflow,
   // serial pins
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd,
   // flag request to the processor
   output logic irq_req
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser

   logic [1:0] rxd_sync_reg;
   logic rxd_s;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rxd_sync_reg <= 2'h3;
      end else begin
         rxd_sync_reg <= {rxd_sync_reg[0], rxd_in};
      end
   end
   assign rxd_s = rxd_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states

   sp_pkg::sp_ahb_req_t dph_reg;
   sp_pkg::sp_ctrl_t ctrl_reg;
   sp_pkg::sp_ctrl_t ctrl_wr;
   logic [7:0] tbuf_reg;
   logic [7:0] rx_buf_reg;
   logic wr_ctrl;
   logic wr_buf;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dph_reg <= '0;
      end else if (hready) begin
         dph_reg.valid <= hsel && htrans[1];
         dph_reg.write <= hwrite;
         dph_reg.addr <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_ctrl = dph_reg.valid && dph_reg.write &&
                    dph_reg.addr == `SP_CTRL_OFS;
   assign wr_buf = dph_reg.valid && dph_reg.write &&
                   dph_reg.addr == `SP_BUF_OFS;
   assign ctrl_wr = sp_pkg::sp_ctrl_t'(hwdata[8:0]);

   // reads see register contents during the data phase
   always_comb begin
      hrdata = 32'h0000_0000;
      if (dph_reg.valid && !dph_reg.write) begin
         if (dph_reg.addr == `SP_CTRL_OFS) begin
            hrdata = {23'h00_0000, ctrl_reg};
         end else if (dph_reg.addr == `SP_BUF_OFS) begin
            hrdata = {24'h00_0000, rx_buf_reg};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tbuf_reg <= `SP_BUF_RESET;
      end else if (wr_buf) begin
         tbuf_reg <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register and flags

   logic mode_sync;
   logic mode_async;
   logic m0_tx_done;
   logic m0_rx_done;
   logic m1_tx_done;
   logic m1_accept;
   logic m1_vote;

   assign mode_sync = {ctrl_reg.mode_select_high, ctrl_reg.mode_select_low}
                      == `SP_MODE_SYNC;
   assign mode_async = {ctrl_reg.mode_select_high, ctrl_reg.mode_select_low}
                       == `SP_MODE_ASYNC;

   // a hardware set in the cycle of a software clear wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_reg <= `SP_CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= ctrl_wr;
            ctrl_reg.spare <= 1'b0;
         end
         ctrl_reg.tx_done_flag <= m0_tx_done || m1_tx_done ||
            (wr_ctrl ? ctrl_wr.tx_done_flag : ctrl_reg.tx_done_flag);
         ctrl_reg.rx_done_flag <= m0_rx_done || m1_accept ||
            (wr_ctrl ? ctrl_wr.rx_done_flag : ctrl_reg.rx_done_flag);
         if (m1_accept) begin
            ctrl_reg.rx_ninth_bit <= m1_vote;
         end
      end
   end

   assign irq_req = ctrl_reg.tx_done_flag || ctrl_reg.rx_done_flag;

   ////////////////////////////////////////////////////////////////////////////
   // synchronous mode shifter

   sp_pkg::sp_m0_state_t m0_state_reg;
   logic [3:0] m0_ph_reg;
   logic [3:0] m0_ph_next;
   logic [2:0] m0_bit_reg;
   logic [7:0] m0_sh_reg;
   logic m0_sclk_reg;
   logic m0_sclk_next;
   logic [3:0] m0_per;
   logic [3:0] m0_lead;
   logic [3:0] m0_rise;
   logic m0_start_tx;
   logic m0_start_rx;
   logic m0_busy;
   logic m0_busy_next;
   logic m0_end_ph;
   logic m0_rise_ph;

   assign m0_per = ctrl_reg.multiproc_rate_bit ? `SP_M0_FAST_PER
                                               : `SP_M0_SLOW_PER;
   assign m0_lead = ctrl_reg.multiproc_rate_bit ? `SP_M0_FAST_LEAD
                                                : `SP_M0_SLOW_LEAD;
   assign m0_rise = ctrl_reg.multiproc_rate_bit ? `SP_M0_FAST_RISE
                                                : `SP_M0_SLOW_RISE;

   assign m0_busy = m0_state_reg != sp_pkg::SP_M0_IDLE;
   assign m0_start_tx = mode_sync && !m0_busy && wr_buf;
   assign m0_start_rx = mode_sync && !m0_busy && !wr_buf &&
      ctrl_reg.rx_enable && !ctrl_reg.rx_done_flag;
   assign m0_end_ph = m0_ph_reg == m0_per - 4'h1;
   assign m0_rise_ph = m0_ph_reg == m0_rise;
   // transmit ends after its last period, receive at its last rising edge
   assign m0_tx_done = m0_state_reg == sp_pkg::SP_M0_TX && m0_end_ph &&
                       m0_bit_reg == `SP_M0_LAST_BIT;
   assign m0_rx_done = m0_state_reg == sp_pkg::SP_M0_RX && m0_rise_ph &&
                       m0_bit_reg == `SP_M0_LAST_BIT;

   always_comb begin
      m0_busy_next = m0_start_tx || m0_start_rx ||
                     (m0_busy && !m0_tx_done && !m0_rx_done);
      if (!m0_busy || m0_end_ph) begin
         m0_ph_next = 4'h0;
      end else begin
         m0_ph_next = m0_ph_reg + 4'h1;
      end
      // clock low from the lead phase up to the rising phase
      m0_sclk_next = !(m0_busy_next && m0_ph_next >= m0_lead &&
                       m0_ph_next < m0_rise);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         m0_state_reg <= sp_pkg::SP_M0_IDLE;
         m0_ph_reg <= 4'h0;
         m0_bit_reg <= 3'h0;
         m0_sh_reg <= 8'hff;
         m0_sclk_reg <= 1'b1;
      end else begin
         m0_ph_reg <= m0_ph_next;
         m0_sclk_reg <= m0_sclk_next;
         unique case (m0_state_reg)
            sp_pkg::SP_M0_IDLE: begin
               m0_bit_reg <= 3'h0;
               if (m0_start_tx) begin
                  m0_state_reg <= sp_pkg::SP_M0_TX;
                  m0_sh_reg <= hwdata[7:0];
               end else if (m0_start_rx) begin
                  m0_state_reg <= sp_pkg::SP_M0_RX;
               end
            end
            sp_pkg::SP_M0_TX: begin
               if (m0_end_ph) begin
                  m0_sh_reg <= {1'b1, m0_sh_reg[7:1]};
                  m0_bit_reg <= m0_bit_reg + 3'h1;
                  if (m0_tx_done) begin
                     m0_state_reg <= sp_pkg::SP_M0_IDLE;
                  end
               end
            end
            sp_pkg::SP_M0_RX: begin
               // partner holds data stable across the rising edge
               if (m0_rise_ph) begin
                  m0_sh_reg <= {rxd_s, m0_sh_reg[7:1]};
                  m0_bit_reg <= m0_bit_reg + 3'h1;
                  if (m0_rx_done) begin
                     m0_state_reg <= sp_pkg::SP_M0_IDLE;
                  end
               end
            end
            default: begin
               m0_state_reg <= sp_pkg::SP_M0_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous mode: slice tick and transmitter

   logic half_reg;
   logic tick;
   logic [3:0] tx1_cnt_reg;
   logic tx1_roll;
   logic tx1_pend_reg;
   logic tx1_busy_reg;
   logic [3:0] tx1_bit_reg;
   logic [7:0] tx1_sh_reg;
   logic tx1_line_reg;

   // overflow halved unless double rate is selected
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         half_reg <= 1'b0;
      end else if (timer_overflow) begin
         half_reg <= !half_reg;
      end
   end
   assign tick = timer_overflow && (ctrl_reg.double_rate || half_reg);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tx1_cnt_reg <= 4'h0;
      end else if (tick) begin
         tx1_cnt_reg <= tx1_cnt_reg + 4'h1;
      end
   end
   assign tx1_roll = tick && tx1_cnt_reg == `SP_M1_LAST_SLICE;
   assign m1_tx_done = tx1_roll && tx1_busy_reg &&
                       tx1_bit_reg == `SP_M1_TX_STOP;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tx1_pend_reg <= 1'b0;
         tx1_busy_reg <= 1'b0;
         tx1_bit_reg <= 4'h0;
         tx1_sh_reg <= 8'hff;
         tx1_line_reg <= 1'b1;
      end else begin
         if (wr_buf && mode_async) begin
            tx1_pend_reg <= 1'b1;
         end
         if (tx1_roll) begin
            if (tx1_busy_reg) begin
               tx1_bit_reg <= tx1_bit_reg + 4'h1;
               if (tx1_bit_reg == `SP_M1_TX_END) begin
                  tx1_busy_reg <= 1'b0;
               end else if (tx1_bit_reg == `SP_M1_TX_STOP) begin
                  tx1_line_reg <= 1'b1;
               end else begin
                  tx1_line_reg <= tx1_sh_reg[0];
                  tx1_sh_reg <= {1'b1, tx1_sh_reg[7:1]};
               end
            end else if (tx1_pend_reg && !(wr_buf && mode_async)) begin
               tx1_pend_reg <= 1'b0;
               tx1_busy_reg <= 1'b1;
               tx1_bit_reg <= 4'h1;
               tx1_sh_reg <= tbuf_reg;
               tx1_line_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous mode: receiver

   sp_pkg::sp_rx1_state_t rx1_state_reg;
   logic rx1_prev_reg;
   logic [3:0] rx1_cnt_reg;
   logic [3:0] rx1_bit_reg;
   logic rx1_sa_reg;
   logic rx1_sb_reg;
   logic [7:0] rx1_sh_reg;
   logic rx1_vote_now;

   assign m1_vote = (rx1_sa_reg && rx1_sb_reg) || (rx1_sa_reg && rxd_s) ||
                    (rx1_sb_reg && rxd_s);
   assign rx1_vote_now = tick && rx1_state_reg == sp_pkg::SP_RX1_RECV &&
                         rx1_cnt_reg == `SP_M1_VOTE_C;
   assign m1_accept = rx1_vote_now && rx1_bit_reg == `SP_M1_RX_LAST &&
      !ctrl_reg.rx_done_flag &&
      (!ctrl_reg.multiproc_rate_bit || m1_vote);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rx1_state_reg <= sp_pkg::SP_RX1_HUNT;
         rx1_prev_reg <= 1'b1;
         rx1_cnt_reg <= 4'h0;
         rx1_bit_reg <= 4'h0;
         rx1_sa_reg <= 1'b1;
         rx1_sb_reg <= 1'b1;
         rx1_sh_reg <= 8'h00;
      end else if (!mode_async || !ctrl_reg.rx_enable) begin
         rx1_state_reg <= sp_pkg::SP_RX1_HUNT;
         rx1_prev_reg <= 1'b1;
      end else if (tick) begin
         rx1_prev_reg <= rxd_s;
         unique case (rx1_state_reg)
            sp_pkg::SP_RX1_HUNT: begin
               if (rx1_prev_reg && !rxd_s) begin
                  rx1_state_reg <= sp_pkg::SP_RX1_RECV;
                  rx1_cnt_reg <= 4'h0;
                  rx1_bit_reg <= 4'h0;
               end
            end
            sp_pkg::SP_RX1_RECV: begin
               rx1_cnt_reg <= rx1_cnt_reg + 4'h1;
               if (rx1_cnt_reg == `SP_M1_VOTE_A) begin
                  rx1_sa_reg <= rxd_s;
               end
               if (rx1_cnt_reg == `SP_M1_VOTE_B) begin
                  rx1_sb_reg <= rxd_s;
               end
               if (rx1_vote_now) begin
                  rx1_bit_reg <= rx1_bit_reg + 4'h1;
                  if (rx1_bit_reg == 4'h0 && m1_vote) begin
                     rx1_state_reg <= sp_pkg::SP_RX1_HUNT;
                  end else if (rx1_bit_reg == `SP_M1_RX_LAST) begin
                     rx1_state_reg <= sp_pkg::SP_RX1_HUNT;
                  end else if (rx1_bit_reg != 4'h0) begin
                     rx1_sh_reg <= {m1_vote, rx1_sh_reg[7:1]};
                  end
               end
            end
            default: begin
               rx1_state_reg <= sp_pkg::SP_RX1_HUNT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer and pins

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rx_buf_reg <= `SP_BUF_RESET;
      end else if (m0_rx_done) begin
         rx_buf_reg <= {rxd_s, m0_sh_reg[7:1]};
      end else if (m1_accept) begin
         rx_buf_reg <= rx1_sh_reg;
      end
   end

   // transmit pin carries the shift clock in sync mode, else the frame
   assign txd = mode_sync ? m0_sclk_reg : tx1_line_reg;
   assign rxd_oe = m0_state_reg == sp_pkg::SP_M0_TX;
   assign rxd_out = m0_sh_reg[0];

endmodule : sp_serial_port

// ### tb/sp_line_partner.sv
// line-side partner: sync shift register and async terminal
`timescale 1ns/1ns
module sp_line_partner (
   // clock
   input wire logic clock,
   // line pins
   input wire logic txd,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   output logic rxd_drive
);
   logic txd_q = 1'b1;
   logic async_mode = 1'b0;
   logic [7:0] got_byte = 8'h00;
   logic [7:0] sync_src = 8'hff;
   int rises = 0;
   int cyc = 0;
   int first_rise = 0;
   int last_rise = 0;
   int bit_cycles = 128;
   // the receive pin has a pull-up, so a released line reads high
   initial rxd_drive = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      cyc <= cyc + 1;
      txd_q <= txd;
      if (!async_mode && txd && !txd_q) begin
         if (rises == 0) first_rise <= cyc;
         last_rise <= cyc;
         rises <= rises + 1;
         if (rxd_oe) got_byte <= {rxd_out, got_byte[7:1]};
         if (!rxd_oe && rises == 7) rxd_drive <= 1'b1;
      end
   end
   // shift on the falling edge itself: a cycle late misses the synchroniser
   always @(negedge txd) begin
      if (!async_mode && !rxd_oe && rises < 8) begin
         rxd_drive <= sync_src[0];
         sync_src <= sync_src >> 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic send_async(input logic [7:0] b, input logic stop,
         input int stop_len);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_drive <= f[i];
         repeat (i == 9 ? stop_len : bit_cycles) @(posedge clock);
      end
      if (!stop) rxd_drive <= 1'b1;
   endtask : send_async
   task automatic glitch(input int len);
      rxd_drive <= 1'b0;
      repeat (len) @(posedge clock);
      rxd_drive <= 1'b1;
   endtask : glitch
   // samples each bit in its middle, counted from the start edge
   task automatic recv_async(output logic [7:0] b, output logic stop);
      logic [9:0] f;
      @(posedge clock);
      while (!(txd_q && !txd)) @(posedge clock);
      repeat (bit_cycles / 2) @(posedge clock);
      f[0] = txd;
      for (int i = 1; i < 10; i++) begin
         repeat (bit_cycles) @(posedge clock);
         f[i] = txd;
      end
      b = f[8:1];
      stop = f[9];
   endtask : recv_async
endmodule : sp_line_partner

// ### tb/sp_serial_port_bench.sv
// self-checking bench for the serial port
`timescale 1ns/1ns
`include "sp_consts.svh"
module sp_serial_port_bench;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic timer_overflow = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [2:0] tick_div = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd, e;
   logic hreadyout, hresp, rxd_in, rxd_out, rxd_oe, txd, irq_req, rxd_drive;
   logic [7:0] byte_seen;
   logic stop_seen;
   int span;
   int failures = 0;
   int checks_done = 0;
   // shared receive pin: the device wins while it drives
   assign rxd_in = rxd_oe ? rxd_out : rxd_drive;
   sp_serial_port dut (.clock(clock), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .timer_overflow(timer_overflow),
      .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
      .irq_req(irq_req));
   sp_line_partner partner (.clock(clock), .txd(txd), .rxd_out(rxd_out),
      .rxd_oe(rxd_oe), .rxd_drive(rxd_drive));
   initial forever #25 clock = ~clock;
   // overflow pulse every 8 clocks, a 400 ns period
   always @(posedge clock) begin
      tick_div <= tick_div + 3'h1;
      timer_overflow <= tick_div == 3'h7;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic rd_check(input string what, input logic [7:0] a,
         input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask : rd_check
   // polls the control register; a lost flag ends in a mismatch
   task automatic wait_flag(input int idx);
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[idx] !== 1'b1 && n < 3000) begin
         xfer(1'b0, `SP_CTRL_OFS, 32'h0);
         n++;
      end
      check("done flag", 32'h1, {31'h0, rd[idx]});
   endtask : wait_flag
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(80000 * 50);
      failures++;
      $display("ERROR watchdog expected end seen timeout");
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd_check("ctrl reset", `SP_CTRL_OFS, 32'h0);
      rd_check("buffer reset", `SP_BUF_OFS, 32'h0);
      xfer(1'b1, `SP_CTRL_OFS, 32'h1fb);
      rd_check("ctrl readback", `SP_CTRL_OFS, 32'h1f3);
      check("irq raised", 32'h1, {31'h0, irq_req});
      xfer(1'b1, 8'h08, 32'hff);
      rd_check("unmapped", 8'h08, 32'h0);
      xfer(1'b1, `SP_CTRL_OFS, 32'h0);
      // the write lands at the edge that ends xfer; look one edge later
      @(posedge clock);
      check("irq cleared", 32'h0, {31'h0, irq_req});
      for (int f = 0; f < 2; f++) begin
         e = f ? 32'ha5 : 32'h3c;
         xfer(1'b1, `SP_CTRL_OFS, f ? 32'h020 : 32'h000);
         partner.rises = 0;
         xfer(1'b1, `SP_BUF_OFS, e);
         wait_flag(1);
         check("m0 tx", e, {24'h0, partner.got_byte});
         span = partner.last_rise - partner.first_rise;
         check("m0 span", f ? 32'h1c : 32'h54, 32'(span));
      end
      partner.sync_src = 8'h96;
      partner.rises = 0;
      xfer(1'b1, `SP_CTRL_OFS, 32'h030);
      wait_flag(0);
      rd_check("m0 rx", `SP_BUF_OFS, 32'h96);
      repeat (40) @(posedge clock);
      check("m0 stall", 32'h8, 32'(partner.rises));
      partner.async_mode = 1'b1;
      for (int f = 0; f < 2; f++) begin
         e = f ? 32'h5a : 32'hc6;
         partner.bit_cycles = f ? 128 : 256;
         xfer(1'b1, `SP_CTRL_OFS, f ? 32'h140 : 32'h040);
         fork
            partner.recv_async(byte_seen, stop_seen);
            xfer(1'b1, `SP_BUF_OFS, e);
         join
         check("m1 tx", e, {24'h0, byte_seen});
         check("m1 stop", 32'h1, {31'h0, stop_seen});
         wait_flag(1);
      end
      xfer(1'b1, `SP_CTRL_OFS, 32'h150);
      partner.send_async(8'hc3, 1'b1, 128);
      wait_flag(0);
      rd_check("m1 rx", `SP_BUF_OFS, 32'hc3);
      rd_check("m1 ninth", `SP_CTRL_OFS, 32'h155);
      partner.send_async(8'h11, 1'b1, 128);
      rd_check("m1 held", `SP_BUF_OFS, 32'hc3);
      xfer(1'b1, `SP_CTRL_OFS, 32'h170);
      partner.send_async(8'h22, 1'b0, 128);
      repeat (64) @(posedge clock);
      rd_check("m1 no stop", `SP_CTRL_OFS, 32'h170);
      partner.glitch(24);
      repeat (200) @(posedge clock);
      // short stop bit: the next start edge falls in its second half
      fork
         begin
            partner.send_async(8'h7e, 1'b1, 88);
            partner.send_async(8'h81, 1'b1, 128);
         end
         begin
            wait_flag(0);
            rd_check("m1 after abort", `SP_BUF_OFS, 32'h7e);
            xfer(1'b1, `SP_CTRL_OFS, 32'h150);
         end
      join
      wait_flag(0);
      rd_check("m1 short stop", `SP_BUF_OFS, 32'h81);
      end_of_test();
   end
endmodule : sp_serial_port_bench

bind sp_serial_port sp_serial_port_properties props (.clock(clock),
   .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
   .txd(txd), .irq_req(irq_req));

// ### tb/sp_serial_port_properties.sv
// concurrent checks on the serial port bus and pins
`timescale 1ns/1ns
`include "sp_consts.svh"
module sp_serial_port_properties (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // pins
   input wire logic rxd_out,
   input wire logic rxd_oe,
   input wire logic txd,
   input wire logic irq_req
);
   logic taken;
   logic rd_dp;
   logic ctl_wr;
   logic buf_wr;
   logic [7:0] oe_cnt;
   logic [3:0] fall_cnt;
   logic txd_q;
   assign taken = hsel && htrans[1] && hready;
   ////////////////////////////////////////////////////////////////////////
   // which data phase is running now
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_dp <= 1'b0;
         ctl_wr <= 1'b0;
         buf_wr <= 1'b0;
      end else begin
         rd_dp <= taken && !hwrite;
         ctl_wr <= taken && hwrite && haddr[7:0] == `SP_CTRL_OFS;
         buf_wr <= taken && hwrite && haddr[7:0] == `SP_BUF_OFS;
      end
   end
   // length of a driven sync frame, in clocks and in shift clock falls
   always_ff @(posedge clock or posedge reset) begin
      if (reset || !rxd_oe) begin
         oe_cnt <= 8'h00;
         fall_cnt <= 4'h0;
         txd_q <= 1'b1;
      end else begin
         oe_cnt <= oe_cnt + 8'h01;
         fall_cnt <= fall_cnt + {3'h0, txd_q && !txd};
         txd_q <= txd;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence low_fast;
      (!txd) [*2] ##1 txd;
   endsequence
   sequence low_slow;
      (!txd) [*6] ##1 txd;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_rdata_idle: assert property (!rd_dp |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   a_irq_clear: assert property (
      $fell(irq_req) |-> $past(ctl_wr) || $past(ctl_wr, 2))
      else $error("interrupt request dropped without a control write");
   a_oe_on_write: assert property ($rose(rxd_oe) |-> $past(buf_wr))
      else $error("receive pin driven without a buffer write");
   a_clock_low: assert property (
      $fell(txd) && rxd_oe |-> low_fast or low_slow)
      else $error("shift clock low phase of wrong length");
   a_data_lead: assert property (
      $fell(txd) && rxd_oe |-> $stable(rxd_out) ##1 $stable(rxd_out))
      else $error("data not set up ahead of the shift clock fall");
   a_frame_len: assert property (
      $fell(rxd_oe) |-> fall_cnt == 4'h8 &&
      (oe_cnt == 8'h20 || oe_cnt == 8'h60))
      else $error("sync frame clock count or length wrong");
   a_reset_idle: assert property (
      $fell(reset) |-> txd && !rxd_oe && !irq_req)
      else $error("pins not idle after reset");
endmodule : sp_serial_port_properties
